/* File: verilog/eeprom_cfg.svh */
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// clock and timing
`define CLK_PERIOD_NS 8
`define CLK_RATE_KHZ 125000
`define PROGRAM_INTERVAL_US 4000
`define SELECT_LOW_TIME_NS 200
// longest programming time, rounded down to whole cycles
`define PROGRAM_CYCLES ((`PROGRAM_INTERVAL_US * (`CLK_RATE_KHZ / 1000)))
// least select low time, rounded up to whole cycles
`define SELECT_LOW_CYCLES ((`SELECT_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// serial clock positions counted from the start bit
`define BIT_START 5'h01
`define BIT_ADDR_LAST 5'h09
`define BIT_DATA_LAST 5'h19

// opcodes and extended codes in the two top address bits
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_MISC 2'h0
`define MISC_UNLOCK 2'h3
`define MISC_FILL 2'h1
`define MISC_LOCK 2'h0

// array geometry
`define WORD_COUNT 64
`define WORD_MSB 4'hf

`endif

/* File: verilog/eeprom_pkg.sv */
package eeprom_pkg;

    // one programming job handed to the engine
    typedef struct packed {
        logic fill_all;
        logic [5:0] addr;
        logic [15:0] data;
    } prog_req_t;

    // serial front end states
    typedef enum logic [2:0] {
        FS_IDLE = 3'b000,
        FS_SHIFT = 3'b001,
        FS_ARMED = 3'b010,
        FS_READ = 3'b011,
        FS_DONE = 3'b100
    } front_state_t;

    // programming engine states
    typedef enum logic [0:0] {
        EN_IDLE = 1'b0,
        EN_PROG = 1'b1
    } engine_state_t;

endpackage : eeprom_pkg

/* File: verilog/prog_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer between the serial front end and the programming engine
module prog_buffer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire eeprom_pkg::prog_req_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output eeprom_pkg::prog_req_t out_data
);

    eeprom_pkg::prog_req_t slot_q [2]; // storage slots
    eeprom_pkg::prog_req_t slot0_d;
    eeprom_pkg::prog_req_t slot1_d;
    logic wr_ptr_q, wr_ptr_d; // next slot to fill
    logic rd_ptr_q, rd_ptr_d; // next slot to drain
    logic [1:0] count_q, count_d; // occupancy, 0 to 2
    logic push, pop;

    // next-state logic for pointers, count and slots
    always_comb begin
        push = in_valid && (count_q != 2'h2);
        pop = (count_q != 2'h0) && out_ready;
        wr_ptr_d = push ? ~wr_ptr_q : wr_ptr_q;
        rd_ptr_d = pop ? ~rd_ptr_q : rd_ptr_q;
        count_d = count_q + {1'b0, push} - {1'b0, pop};
        slot0_d = (push && !wr_ptr_q) ? in_data : slot_q[0];
        slot1_d = (push && wr_ptr_q) ? in_data : slot_q[1];
    end

    // register stage; empty after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            slot_q[0] <= slot0_d;
            slot_q[1] <= slot1_d;
        end
    end

    assign in_ready = (count_q != 2'h2); // honest full
    assign out_valid = (count_q != 2'h0); // honest empty
    assign out_data = slot_q[rd_ptr_q];

endmodule : prog_buffer

`default_nettype wire

/* File: verilog/serial_eeprom_write_control.sv */
// Behaviour
// [R01] write stores 16-bit word at six-bit address
// [R02] program starts on select fall in window
// [R03] select fall after 26th clock discards write
// [R04] programming self-times, 4 ms at most
// [R05] host sends nothing while busy is shown
// [R06] commands ignored while busy, accepted when ready
// [R07] host holds select past clock high time
// [R08] fill-all stores word everywhere, 4 ms
// [R09] fill-all ended after 26th clock is dropped
// [R10] reset leaves writes locked
// [R11] unlock keeps writes allowed until lock
// [R12] reads work whether locked or not
// [R13] host clocks on past sixth clock for unlock/lock
// [R14] lock returns to power-up locked state
// [R15] select low before 25th clock cancels
// [R16] no cancel from 25th clock to completion
// [R17] after 26th clock, select low cancels
// [R18] serial output released except status or read
// [R19] status after 200 ns: busy low, ready high
// [R20] start bit stops status output
// [R21] all inputs high at ready acts as start
// [R22] host keeps serial input low while selected
// [R23] command opens with first one after select
// [R24] serial input sampled on serial clock rise
// [R25] host drops select after every command
// [R26] one write-enable bit gates write and fill-all
`include "eeprom_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_write_control #(
    parameter int program_cycles = `PROGRAM_CYCLES // shorten for simulation
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic select_in,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic write_enabled,
    output logic busy
);

    // pin synchronisers, two stages each
    logic [1:0] cs_sync_q, sk_sync_q, di_sync_q;
    logic cs_prev_q, sk_prev_q; // edge history after the synchroniser
    logic cs_s, sk_s, di_s;
    logic sk_rise, cs_fall, cs_rise;

    // front end state
    eeprom_pkg::front_state_t fs_q, fs_d;
    logic [4:0] bit_q, bit_d; // serial clocks since the start bit
    logic [23:0] sh_q, sh_d; // opcode, address, data
    logic [23:0] sh_next; // shift register with the current bit
    logic we_q, we_d; // write-enable state
    logic [5:0] rd_addr_q, rd_addr_d; // read pointer
    logic [3:0] rd_bit_q, rd_bit_d; // bit within the read word
    logic rd_drive_q, rd_drive_d; // read data is on the pin
    logic rd_val_q, rd_val_d; // read bit on the pin
    logic stat_armed_q, stat_armed_d; // a write has launched
    logic stat_show_q, stat_show_d; // status is on the pin
    logic [4:0] low_cnt_q, low_cnt_d; // select low time, saturating
    logic push_valid; // launch of a programming job
    logic push_ready;
    eeprom_pkg::prog_req_t push_req;

    // programming engine
    eeprom_pkg::engine_state_t en_q, en_d;
    logic [18:0] timer_q, timer_d;
    eeprom_pkg::prog_req_t job_q, job_d;
    logic job_valid, job_ready;
    eeprom_pkg::prog_req_t job_req;
    logic prog_done; // last cycle of the interval
    logic busy_now; // engine or buffer holds work

    // output flops
    logic do_q, do_d, oe_q, oe_d, busy_q, we_out_q;

    logic [15:0] mem [`WORD_COUNT]; // the array itself, no reset

    // edge history reads only the second synchroniser stage
    assign cs_s = cs_sync_q[1];
    assign sk_s = sk_sync_q[1];
    assign di_s = di_sync_q[1];
    assign sk_rise = cs_s && sk_s && !sk_prev_q; // [R24]
    assign cs_fall = !cs_s && cs_prev_q;
    assign cs_rise = cs_s && !cs_prev_q;
    assign sh_next = {sh_q[22:0], di_s};
    assign busy_now = (en_q == eeprom_pkg::EN_PROG) || job_valid;
    assign prog_done = (en_q == eeprom_pkg::EN_PROG) && (timer_q == 19'(program_cycles - 1));

    // synchroniser and edge registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_q <= 2'h0;
            sk_sync_q <= 2'h0;
            di_sync_q <= 2'h0;
            cs_prev_q <= 1'b0;
            sk_prev_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], select_in};
            sk_sync_q <= {sk_sync_q[0], serial_clock_in};
            di_sync_q <= {di_sync_q[0], serial_in};
            cs_prev_q <= cs_s;
            sk_prev_q <= sk_s;
        end
    end

    // front end: command decode, cancel windows, read and status
    always_comb begin
        fs_d = fs_q;
        bit_d = bit_q;
        sh_d = sh_q;
        we_d = we_q;
        rd_addr_d = rd_addr_q;
        rd_bit_d = rd_bit_q;
        rd_drive_d = rd_drive_q;
        rd_val_d = rd_val_q;
        stat_armed_d = stat_armed_q;
        stat_show_d = stat_show_q;
        push_valid = 1'b0;
        push_req = '{fill_all: (sh_q[23:22] == `OP_MISC), addr: sh_q[21:16], data: sh_q[15:0]};
        // count select low time up to the status threshold
        if (cs_s) begin
            low_cnt_d = low_cnt_q;
        end else if (low_cnt_q < 5'(`SELECT_LOW_CYCLES)) begin
            low_cnt_d = low_cnt_q + 5'h01;
        end else begin
            low_cnt_d = low_cnt_q;
        end
        if (!cs_s) begin
            // select low resets the interface and releases the pin
            fs_d = eeprom_pkg::FS_IDLE; // [R15] [R17]
            bit_d = 5'h00;
            rd_drive_d = 1'b0;
            stat_show_d = 1'b0;
            if (cs_fall && fs_q == eeprom_pkg::FS_ARMED && push_ready) begin
                push_valid = 1'b1; // [R02]
                stat_armed_d = 1'b1;
            end
        end else begin
            if (cs_rise) begin
                stat_show_d = stat_armed_q && (low_cnt_q >= 5'(`SELECT_LOW_CYCLES)); // [R19]
            end
            case (fs_q)
                eeprom_pkg::FS_IDLE: begin
                    // leading zeros ignored; busy ignores the start bit
                    if ((sk_rise && di_s && !busy_now) || (prog_done && sk_s && di_s)) begin // [R23] [R06] [R21]
                        fs_d = eeprom_pkg::FS_SHIFT;
                        bit_d = `BIT_START;
                        stat_armed_d = 1'b0; // [R20]
                        stat_show_d = 1'b0;
                    end
                end
                eeprom_pkg::FS_SHIFT: begin
                    if (sk_rise) begin
                        bit_d = bit_q + 5'h01;
                        sh_d = sh_next;
                        if (bit_d == `BIT_ADDR_LAST) begin
                            case (sh_next[7:6])
                                `OP_READ: begin
                                    // dummy zero goes out with the last address bit
                                    fs_d = eeprom_pkg::FS_READ; // [R12]
                                    rd_addr_d = sh_next[5:0];
                                    rd_bit_d = `WORD_MSB;
                                    rd_drive_d = 1'b1;
                                    rd_val_d = 1'b0;
                                end
                                `OP_MISC: begin
                                    if (sh_next[5:4] == `MISC_UNLOCK) begin
                                        we_d = 1'b1; // [R11] [R26]
                                        fs_d = eeprom_pkg::FS_DONE;
                                    end else if (sh_next[5:4] == `MISC_LOCK) begin
                                        we_d = 1'b0; // [R14] [R26]
                                        fs_d = eeprom_pkg::FS_DONE;
                                    end else if (sh_next[5:4] != `MISC_FILL) begin
                                        fs_d = eeprom_pkg::FS_DONE;
                                    end
                                end
                                default: begin
                                    fs_d = fs_q; // write keeps shifting data
                                end
                            endcase
                        end else if (bit_d == `BIT_DATA_LAST) begin
                            // disabled writes are dropped here
                            fs_d = we_q ? eeprom_pkg::FS_ARMED : eeprom_pkg::FS_DONE; // [R26] [R10]
                        end
                    end
                end
                eeprom_pkg::FS_ARMED: begin
                    // 26th rise with select still high throws the job away
                    if (sk_rise) begin
                        fs_d = eeprom_pkg::FS_DONE; // [R03] [R09] [R17]
                    end
                end
                eeprom_pkg::FS_READ: begin
                    // continuous clocking walks on through the array
                    if (sk_rise) begin
                        rd_val_d = mem[rd_addr_q][rd_bit_q];
                        rd_bit_d = rd_bit_q - 4'h1;
                        if (rd_bit_q == 4'h0) begin
                            rd_addr_d = rd_addr_q + 6'h01;
                        end
                    end
                end
                default: begin
                    fs_d = fs_q; // done: wait for select low
                end
            endcase
        end
        if (cs_rise) begin
            low_cnt_d = 5'h00;
        end
        do_d = stat_show_d ? !busy_now : rd_val_d; // [R19]
        oe_d = cs_s && (stat_show_d || rd_drive_d); // [R18]
    end

    // front end registers; writes start locked after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_q <= eeprom_pkg::FS_IDLE;
            bit_q <= 5'h00;
            sh_q <= 24'h000000;
            we_q <= 1'b0; // [R10]
            rd_addr_q <= 6'h00;
            rd_bit_q <= 4'h0;
            rd_drive_q <= 1'b0;
            rd_val_q <= 1'b0;
            stat_armed_q <= 1'b0;
            stat_show_q <= 1'b0;
            low_cnt_q <= 5'h00;
            do_q <= 1'b0;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
            we_out_q <= 1'b0;
        end else begin
            fs_q <= fs_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            we_q <= we_d;
            rd_addr_q <= rd_addr_d;
            rd_bit_q <= rd_bit_d;
            rd_drive_q <= rd_drive_d;
            rd_val_q <= rd_val_d;
            stat_armed_q <= stat_armed_d;
            stat_show_q <= stat_show_d;
            low_cnt_q <= low_cnt_d;
            do_q <= do_d;
            oe_q <= oe_d;
            busy_q <= busy_now;
            we_out_q <= we_d;
        end
    end

    // launched jobs wait here; a full buffer refuses the launch
    prog_buffer u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_req),
        .out_valid(job_valid),
        .out_ready(job_ready),
        .out_data(job_req)
    );

    // engine next state: self-timed interval, nothing can stop it
    always_comb begin
        en_d = en_q;
        timer_d = timer_q;
        job_d = job_q;
        job_ready = 1'b0;
        case (en_q)
            eeprom_pkg::EN_IDLE: begin
                if (job_valid) begin
                    job_ready = 1'b1;
                    job_d = job_req;
                    timer_d = 19'h00000;
                    en_d = eeprom_pkg::EN_PROG;
                end
            end
            eeprom_pkg::EN_PROG: begin
                timer_d = timer_q + 19'h00001; // [R16]
                if (prog_done) begin
                    en_d = eeprom_pkg::EN_IDLE; // [R04] [R08]
                end
            end
            default: begin
                en_d = eeprom_pkg::EN_IDLE;
            end
        endcase
    end

    // engine registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= eeprom_pkg::EN_IDLE;
            timer_q <= 19'h00000;
            job_q <= '0;
        end else begin
            en_q <= en_d;
            timer_q <= timer_d;
            job_q <= job_d;
        end
    end

    // array update at the end of the interval
    always_ff @(posedge clk) begin
        if (prog_done) begin
            for (int i = 0; i < `WORD_COUNT; i++) begin
                if (job_q.fill_all || (job_q.addr == 6'(i))) begin
                    mem[i] <= job_q.data; // [R01] [R08]
                end
            end
        end
    end

    assign serial_out = do_q;
    assign serial_out_oe = oe_q;
    assign busy = busy_q;
    assign write_enabled = we_out_q;

endmodule : serial_eeprom_write_control

`default_nettype wire

/* File: bench/eeprom_write_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level checks of the write path, all in the clk domain
module eeprom_write_sva #(
    parameter int program_cycles = 500000 // same span as the design
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic select_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic write_enabled,
    input wire logic busy
);
    int busy_cnt_q; // consecutive busy cycles so far
    int busy_cnt_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // count the busy span; a counter keeps long spans cheap for the tools
    always_comb begin
        busy_cnt_d = busy ? busy_cnt_q + 1 : 0;
    end
    // register the count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    // status enabled well inside a busy span
    sequence busy_settled;
        busy [*3] ##0 serial_out_oe;
    endsequence
    lock_after_reset_a: assert property (!$past(rst_b) |-> !write_enabled)
        else $error("write enable set at reset release");
    busy_gate_a: assert property ($rose(busy) |-> write_enabled)
        else $error("programming started while locked");
    busy_cause_a: assert property ($rose(busy) |-> !$past(select_in, 2))
        else $error("programming started without select fall");
    busy_short_a: assert property ($fell(busy) |-> busy_cnt_q >= program_cycles - 2)
        else $error("programming interval cut short");
    busy_long_a: assert property (busy |-> busy_cnt_q <= program_cycles + 2)
        else $error("programming interval too long");
    busy_status_a: assert property (busy_settled |-> !serial_out)
        else $error("status not low while busy");
    oe_release_a: assert property (!select_in [*6] |-> !serial_out_oe)
        else $error("serial output driven while deselected");
    enable_idle_a: assert property ($changed(write_enabled) |-> !busy && $past(select_in, 3))
        else $error("write enable changed while busy or deselected");
endmodule : eeprom_write_sva
bind serial_eeprom_write_control eeprom_write_sva #(.program_cycles(program_cycles)) u_sva (
    .clk(clk),
    .rst_b(rst_b),
    .select_in(select_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .write_enabled(write_enabled),
    .busy(busy)
);
`default_nettype wire

/* File: bench/eeprom_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the three-wire link
module eeprom_host_model (
    input wire logic clk,
    output logic select_in,
    output logic serial_clock_in,
    output logic serial_in,
    input wire logic serial_out
);
    logic [15:0] rd_q; // last 16 bits seen at the serial output
    // link idles with its clock still and data low
    initial begin
        select_in = 1'b0;
        serial_clock_in = 1'b0;
        serial_in = 1'b0;
        rd_q = 16'h0000;
    end
    // step just past a clk edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // drive select alone, for status polling
    task automatic sel(input logic v);
        select_in = v;
    endtask : sel
    // hold clock and data at one level, for the ready-edge start case
    task automatic hold_all(input logic v);
        serial_clock_in = v;
        serial_in = v;
    endtask : hold_all
    // one serial clock of 20 clk; data set up in the low half
    task automatic bit1(input logic b);
        serial_in = b;
        tick(10);
        serial_clock_in = 1'b1;
        tick(6);
        rd_q = {rd_q[14:0], serial_out};
        tick(4);
        serial_clock_in = 1'b0;
    endtask : bit1
    // one command, msb first; lock codes are clocked to the end too
    task automatic frame(input logic [25:0] bits, input int n);
        int i;
        select_in = 1'b1;
        for (i = 0; i < n; i++) begin
            bit1(bits[25 - i]);
        end
        serial_in = 1'b0;
        tick(10); // select held past the clock high time
        select_in = 1'b0;
        tick(32);
    endtask : frame
endmodule : eeprom_host_model
`default_nettype wire

/* File: bench/tb_serial_eeprom_write_control.sv */
`timescale 1ns/1ps
`default_nettype none
// write-path bench: host model drives the pins, reads prove the writes
module tb_serial_eeprom_write_control;
    localparam int prog_cycles = 200; // short programming span
    logic clk;
    logic rst_b;
    wire logic select_in;
    wire logic serial_clock_in;
    wire logic serial_in;
    wire logic serial_out;
    wire logic serial_out_oe;
    wire logic write_enabled;
    wire logic busy;
    wire logic do_line; // serial output as the host sees it
    int miscompares;
    int compares;
    // 125 MHz clock
    always #4 clk = ~clk;
    // a released output floats up through its pull-up
    assign do_line = serial_out_oe ? serial_out : 1'b1;
    serial_eeprom_write_control #(.program_cycles(prog_cycles)) u_dut (
        .clk(clk),
        .rst_b(rst_b),
        .select_in(select_in),
        .serial_clock_in(serial_clock_in),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .write_enabled(write_enabled),
        .busy(busy)
    );
    eeprom_host_model u_host (
        .clk(clk),
        .select_in(select_in),
        .serial_clock_in(serial_clock_in),
        .serial_in(serial_in),
        .serial_out(do_line)
    );
    // step just past a clk edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // compare a data word
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    // compare a single flag
    task automatic check_flag(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask : check_flag
    // start bit, opcode, address, data, then a spare 26th bit
    function automatic logic [25:0] cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
        return {1'b1, op, a, d, 1'b0};
    endfunction : cmd
    // read one word back through the same pins
    task automatic read_check(input logic [5:0] a, input logic [15:0] exp);
        u_host.frame(cmd(2'h2, a, 16'h0000), 25);
        check_word(u_host.rd_q, exp);
    endtask : read_check
    // wait for busy to drop, bounded by the programming span
    task automatic wait_idle;
        int k;
        for (k = 0; k < prog_cycles + 40 && busy === 1'b1; k++) begin
            tick(1);
        end
        check_flag(busy, 1'b0);
    endtask : wait_idle
    // after reset writes stay locked
    task automatic t_locked;
        check_flag(write_enabled, 1'b0);
        check_flag(serial_out_oe, 1'b0);
        u_host.frame(cmd(2'h1, 6'h15, 16'hbeef), 25);
        check_flag(busy, 1'b0);
    endtask : t_locked
    // unlock, then a write with status polling
    task automatic t_write;
        u_host.frame(cmd(2'h0, 6'h30, 16'h0000), 25);
        check_flag(write_enabled, 1'b1);
        u_host.frame(cmd(2'h1, 6'h15, 16'ha55a), 25);
        check_flag(busy, 1'b1);
        u_host.sel(1'b1);
        tick(6);
        check_flag(serial_out_oe, 1'b1);
        check_flag(serial_out, 1'b0);
        wait_idle();
        tick(3);
        check_flag(serial_out, 1'b1);
        u_host.bit1(1'b1);
        check_flag(serial_out_oe, 1'b0);
        u_host.sel(1'b0);
        tick(32);
        read_check(6'h15, 16'ha55a);
    endtask : t_write
    // late select fall or early cancel leaves the word alone
    task automatic t_cancel;
        u_host.frame(cmd(2'h1, 6'h15, 16'h1111), 26);
        check_flag(busy, 1'b0);
        u_host.frame(cmd(2'h1, 6'h15, 16'h2222), 20);
        check_flag(busy, 1'b0);
        read_check(6'h15, 16'ha55a);
    endtask : t_cancel
    // fill-all: late fall dropped, timely fall fills every word
    task automatic t_fill;
        u_host.frame(cmd(2'h0, 6'h10, 16'h3333), 26);
        check_flag(busy, 1'b0);
        u_host.frame(cmd(2'h0, 6'h10, 16'h5a0f), 25);
        check_flag(busy, 1'b1);
        // a write sent on purpose while busy must leave word 0 alone
        u_host.frame(cmd(2'h1, 6'h00, 16'h0000), 25);
        wait_idle();
        read_check(6'h00, 16'h5a0f);
        read_check(6'h3f, 16'h5a0f);
    endtask : t_fill
    // start bit held across the ready edge stops the status output
    task automatic t_ready_start;
        u_host.frame(cmd(2'h1, 6'h2a, 16'hc3c3), 25);
        check_flag(busy, 1'b1);
        u_host.sel(1'b1);
        tick(6);
        check_flag(serial_out_oe, 1'b1);
        u_host.hold_all(1'b1);
        wait_idle();
        tick(3);
        check_flag(serial_out_oe, 1'b0);
        u_host.hold_all(1'b0);
        u_host.sel(1'b0);
        tick(32);
        read_check(6'h2a, 16'hc3c3);
    endtask : t_ready_start
    // lock: writes dropped, reads still served
    task automatic t_lock;
        u_host.frame(cmd(2'h0, 6'h00, 16'h0000), 25);
        check_flag(write_enabled, 1'b0);
        u_host.frame(cmd(2'h1, 6'h3f, 16'h7777), 25);
        check_flag(busy, 1'b0);
        read_check(6'h3f, 16'h5a0f);
    endtask : t_lock
    // verdict and end of run
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        miscompares = 0;
        compares = 0;
        tick(6);
        rst_b = 1'b1;
        tick(4);
        t_locked();
        t_write();
        t_cancel();
        t_fill();
        t_ready_start();
        t_lock();
        test_done();
    end
    // watchdog, well past the expected run of about 80 us
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
endmodule : tb_serial_eeprom_write_control
`default_nettype wire
